// ### ssu_pkg.sv
// ==========================================================
// Shared constants and state types
package ssu_pkg;

    // ======================================================
    // Frame and shift clock timing
    localparam int          SSU_FRAME_BITS     = 8;
    localparam int          SSU_CLK_PERIOD_NS  = 25;
    localparam int          SSU_SCK_PERIOD_NS  = 1000;
    // Half shift clock period, rounded down to whole cycles
    localparam logic [5:0]  SSU_HALF_CYC       = 6'((SSU_SCK_PERIOD_NS / 2) / SSU_CLK_PERIOD_NS);
    // Two toggles per data bit
    localparam logic [4:0]  SSU_FRAME_TOGGLES  = 5'(2 * SSU_FRAME_BITS);
    localparam logic [2:0]  SSU_LAST_BIT       = 3'(SSU_FRAME_BITS - 1);

    // ======================================================
    // Reset values
    localparam logic [7:0]  SSU_DATA_RST       = 8'h00;
    localparam logic        SSU_SCK_IDLE       = 1'b0;
    localparam logic        SSU_OUT_IDLE       = 1'b1;

    // ======================================================
    // State of the control side (peripheral clock)
    typedef struct packed {
        logic       standby;
        logic [7:0] tx_data;
        logic       tx_empty;
        logic       tx_done;
        logic       rx_full;
        logic       overrun;
        logic [7:0] rx_data;
        logic [7:0] link_word;
        logic       armed;
        logic       busy;
        logic       wait_done;
        logic       sck;
        logic [5:0] div;
        logic [4:0] toggles;
        logic [2:0] done_s;
    } ssu_ctl_t;

    // State of the link side (shift clock)
    typedef struct packed {
        logic [7:0] shreg;
        logic [2:0] cnt;
        logic       done_tgl;
        logic [7:0] rx_word;
    } ssu_link_t;

endpackage

// ### ssu_link_if.sv
`timescale 1ns/100ps
// ==========================================================
// Carrier between the control side and the link shifter
interface ssu_link_if;
    logic [7:0] tx_word;
    logic       run;
    logic       tx_en;
    logic       rx_en;
    logic       done_tgl;
    logic [7:0] rx_word;

    modport ctl  (output tx_word, output run, output tx_en, output rx_en, input done_tgl, input rx_word);
    modport link (input tx_word, input run, input tx_en, input rx_en, output done_tgl, output rx_word);
endinterface

// ### ssu_link_shifter.sv
`timescale 1ns/100ps
// ==========================================================
// Shift register on the shift clock domain
module ssu_link_shifter (
    // Link clock and reset
    input  wire logic      link_clk,
    input  wire logic      rst,
    // Serial data
    input  wire logic      serial_in,
    output logic           serial_out,
    // Control side
    ssu_link_if.link       lk
);

    ssu_pkg::ssu_link_t s_r;
    ssu_pkg::ssu_link_t s_nxt;

    // Sample on every rising edge while run is set; word and controls are held stable by the control side
    always_comb begin
        s_nxt = s_r;
        if (lk.run) begin
            if (s_r.cnt == 3'h0) begin
                s_nxt.shreg = {lk.tx_word[6:0], serial_in};
            end else begin
                s_nxt.shreg = {s_r.shreg[6:0], serial_in};
            end
            s_nxt.cnt = s_r.cnt + 3'h1;
            if (s_r.cnt == ssu_pkg::SSU_LAST_BIT) begin
                // Eighth rising edge ends the frame; the word is kept only while receiving
                if (lk.rx_en) begin
                    s_nxt.rx_word = {s_r.shreg[6:0], serial_in};
                end
                s_nxt.done_tgl = ~s_r.done_tgl;
            end
        end else begin
            s_nxt.cnt = 3'h0;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // First bit comes straight from the loaded word so it is ready before edge one
    always_comb begin
        if (!lk.tx_en) begin
            serial_out = ssu_pkg::SSU_OUT_IDLE;
        end else if (s_r.cnt == 3'h0) begin
            serial_out = lk.tx_word[7];
        end else begin
            serial_out = s_r.shreg[7];
        end
    end

    assign lk.done_tgl = s_r.done_tgl;
    assign lk.rx_word  = s_r.rx_word;

endmodule

// ### ssu_sync_serial.sv
// Behaviour
// - Three lines only: shift clock, serial in, serial out; no chip select.
// - Clearing transmit enable sets tx empty; receive side keeps its flags and data.
// - Master drives clock and data; slave shifts out on the external clock.
// - Transmit write clears empty, loads shift register, sets empty, starts frame.
// - At frame end with pending data, next frame starts automatically.
// - Eighth bit out with nothing pending sets and holds tx done.
// - No transmission while overrun is set; software checks it first.
// - Reception starts once receive enable is set; no dummy read needed.
// - Master clocks while receiving; slave samples on external clock.
// - Each received frame is stored and sets rx full, with optional interrupt.
// - Reading the receive data clears rx full.
// - Rx full at eighth edge sets overrun, error interrupt, stops reception.
// - No reception while overrun set; software clears it to resume.
// - Both enables: write starts full duplex; overrun stops both directions.
// - Five interrupt sources; only rx full and tx empty request DMA; four here, with no conflict source.
// - Overrun and conflict share error line; tx empty and done share tx line; error line carries only overrun here.
// - Requests follow conditions; cleared by processor or DMA access.
// - Held in standby after reset until standby is released.
// - Shift clock pin outputs in master role, input in slave role.
`timescale 1ns/100ps
module ssu_sync_serial (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Standby control
    input  wire logic       module_standby,
    // Configuration
    input  wire logic       master_select,
    input  wire logic       tx_allow,
    input  wire logic       rx_allow,
    input  wire logic       tx_empty_irq_en,
    input  wire logic       tx_done_irq_en,
    input  wire logic       rx_full_irq_en,
    // Data access
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_wdata,
    input  wire logic       rx_rd,
    input  wire logic       overrun_clr,
    output logic      [7:0] rx_data_reg,
    // Status
    output logic            tx_empty_flag,
    output logic            tx_done_flag,
    output logic            rx_full_flag,
    output logic            overrun_flag,
    // Interrupts and DMA
    output logic            tx_irq,
    output logic            rx_irq,
    output logic            error_irq,
    output logic            tx_dma_req,
    output logic            rx_dma_req,
    // Pins
    input  wire logic       shift_clock_pin_i,
    output logic            shift_clock_pin_o,
    output logic            shift_clock_pin_oe_n,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin
);

    ssu_pkg::ssu_ctl_t r_r;
    ssu_pkg::ssu_ctl_t r_nxt;

    ssu_link_if lk ();

    logic done_evt;
    logic go;
    logic run_ok;

    // ======================================================
    // Link shifter, clocked by the shift clock pin itself
    // In master role the pad loops our own clock back, so one shifter serves both roles
    ssu_link_shifter u_link (
        .link_clk   (shift_clock_pin_i),
        .rst        (rst),
        .serial_in  (serial_in_pin),
        .serial_out (serial_out_pin),
        .lk         (lk.link)
    );

    // ======================================================
    // Frame end event from the link domain (toggle, two flops, edge)
    assign done_evt = r_r.done_s[2] ^ r_r.done_s[1];

    // Shifting allowed only with an enable, no overrun and out of standby
    assign run_ok = (tx_allow | rx_allow) & ~r_r.overrun & ~r_r.standby;

    // Master keeps clocking while a word is loaded, or freely in receive-only role
    assign go = master_select & run_ok & (r_r.armed | (rx_allow & ~tx_allow));

    // ======================================================
    // Control state
    always_comb begin
        r_nxt               = r_r;
        r_nxt.standby       = module_standby;
        r_nxt.done_s        = {r_r.done_s[1:0], lk.done_tgl};
        if (!r_r.standby) begin
            // Clears first so that a set in the same cycle wins
            if (rx_rd) begin
                r_nxt.rx_full = 1'b0;
            end
            if (overrun_clr) begin
                r_nxt.overrun = 1'b0;
            end
            // Transmit write
            if (tx_wr && tx_allow && !r_r.overrun) begin
                r_nxt.tx_done = 1'b0;
                if (!r_r.armed) begin
                    // Empty clears and sets again in one step as the word moves on
                    r_nxt.link_word = tx_wdata;
                    r_nxt.armed     = 1'b1;
                    r_nxt.tx_empty  = 1'b1;
                end else begin
                    r_nxt.tx_data  = tx_wdata;
                    r_nxt.tx_empty = 1'b0;
                end
            end
            // Frame end
            if (done_evt) begin
                r_nxt.wait_done = 1'b0;
                if (rx_allow && !r_r.overrun) begin
                    if (r_r.rx_full && !rx_rd) begin
                        r_nxt.overrun = 1'b1;
                    end else begin
                        r_nxt.rx_data = lk.rx_word;
                        r_nxt.rx_full = 1'b1;
                    end
                end
                if (r_r.armed) begin
                    if (!r_r.tx_empty && !r_nxt.overrun) begin
                        r_nxt.link_word = r_r.tx_data;
                        r_nxt.tx_empty  = 1'b1;
                    end else begin
                        r_nxt.armed   = 1'b0;
                        r_nxt.tx_done = 1'b1;
                    end
                end
            end
            // Transmit disable empties the buffer; receive side is left alone
            if (!tx_allow) begin
                r_nxt.tx_empty = 1'b1;
                r_nxt.armed    = 1'b0;
            end
            // Master shift clock divider
            if (r_r.busy) begin
                if (r_r.div == ssu_pkg::SSU_HALF_CYC - 6'h01) begin
                    r_nxt.div     = 6'h00;
                    r_nxt.sck     = ~r_r.sck;
                    r_nxt.toggles = r_r.toggles + 5'h01;
                    // The eighth rise ends the frame at the link; hold the next start until its
                    // event has crossed, which it does well inside the last half period
                    if (r_r.toggles == ssu_pkg::SSU_FRAME_TOGGLES - 5'h02) begin
                        r_nxt.wait_done = 1'b1;
                    end
                    if (r_r.toggles == ssu_pkg::SSU_FRAME_TOGGLES - 5'h01) begin
                        r_nxt.busy = 1'b0;
                    end
                end else begin
                    r_nxt.div = r_r.div + 6'h01;
                end
            end else if (go && !r_r.wait_done && !done_evt) begin
                // Next frame only after the previous one has been accounted for
                r_nxt.busy    = 1'b1;
                r_nxt.div     = 6'h00;
                r_nxt.toggles = 5'h00;
            end
            // Leaving master role or losing enables drops the pending wait
            if (!master_select || !run_ok) begin
                r_nxt.busy      = 1'b0;
                r_nxt.wait_done = 1'b0;
                r_nxt.sck       = ssu_pkg::SSU_SCK_IDLE;
            end
        end
    end

    // ======================================================
    // Registers; standby is held after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r           <= '0;
            r_r.standby   <= 1'b1;
            r_r.tx_empty  <= 1'b1;
            r_r.tx_data   <= ssu_pkg::SSU_DATA_RST;
            r_r.rx_data   <= ssu_pkg::SSU_DATA_RST;
            r_r.link_word <= ssu_pkg::SSU_DATA_RST;
            r_r.sck       <= ssu_pkg::SSU_SCK_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    // ======================================================
    // Link controls; word and levels only change between frames
    assign lk.tx_word = r_r.link_word;
    assign lk.run     = run_ok;
    assign lk.tx_en   = tx_allow & r_r.armed;
    assign lk.rx_en   = rx_allow;

    // Shift clock pin direction follows the role
    assign shift_clock_pin_o    = r_r.sck;
    assign shift_clock_pin_oe_n = ~master_select;

    // ======================================================
    // Status, interrupt lines and DMA requests
    assign rx_data_reg   = r_r.rx_data;
    assign tx_empty_flag = r_r.tx_empty;
    assign tx_done_flag  = r_r.tx_done;
    assign rx_full_flag  = r_r.rx_full;
    assign overrun_flag  = r_r.overrun;
    // Two transmit causes share one line
    assign tx_irq    = (r_r.tx_empty & tx_allow & tx_empty_irq_en) | (r_r.tx_done & tx_done_irq_en);
    assign rx_irq    = r_r.rx_full & rx_full_irq_en;
    // No chip select in this mode, so the error line carries only overrun
    assign error_irq = r_r.overrun;
    assign tx_dma_req = r_r.tx_empty & tx_allow & ~r_r.standby;
    assign rx_dma_req = r_r.rx_full & ~r_r.standby;

endmodule

// ### ssu_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port checks; a single clock domain, so one default clocking
module ssu_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controls
    input wire logic module_standby,
    input wire logic master_select,
    input wire logic tx_allow,
    input wire logic tx_wr,
    input wire logic rx_rd,
    input wire logic overrun_clr,
    input wire logic tx_empty_irq_en,
    input wire logic tx_done_irq_en,
    input wire logic rx_full_irq_en,
    // Status and requests
    input wire logic tx_empty_flag,
    input wire logic tx_done_flag,
    input wire logic rx_full_flag,
    input wire logic overrun_flag,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic error_irq,
    input wire logic tx_dma_req,
    input wire logic rx_dma_req,
    input wire logic shift_clock_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Clock pin direction follows the role; request lines follow the flags
    a_clk_dir: assert property (shift_clock_pin_oe_n == !master_select) else $error("clock pin direction");
    a_err_line: assert property (error_irq == overrun_flag) else $error("error line");
    a_rx_line: assert property (rx_irq == (rx_full_flag && rx_full_irq_en)) else $error("rx line");
    a_tx_line: assert property (tx_irq == ((tx_empty_flag && tx_allow && tx_empty_irq_en)
        || (tx_done_flag && tx_done_irq_en))) else $error("tx line");
    a_dma_src: assert property ((!rx_dma_req || rx_full_flag) && (!tx_dma_req || tx_empty_flag))
        else $error("dma source");
    // Sticky flags keep their state until their own clearing action; tx disable sets empty
    a_tx_off_empty: assert property (!tx_allow && !$past(module_standby) |=> tx_empty_flag)
        else $error("tx empty not set");
    a_ovr_holds: assert property (overrun_flag && !overrun_clr |=> overrun_flag) else $error("overrun lost");
    a_full_holds: assert property (rx_full_flag && !rx_rd |=> rx_full_flag) else $error("rx full lost");
    a_ovr_no_tx: assert property (overrun_flag && tx_wr && tx_allow |=> $stable(tx_empty_flag))
        else $error("write taken in overrun");
    a_done_sticky: assert property (tx_done_flag && !tx_wr && tx_allow |=> tx_done_flag)
        else $error("tx done lost");
    // Main scenarios
    c_overrun: cover property ($rose(overrun_flag));
    c_done: cover property ($rose(tx_done_flag));
    c_full: cover property ($rose(rx_full_flag));
endmodule

// ### ssu_peer.sv
`timescale 1ns/100ps
// ==========================================================
// Far-side device: one byte each way per frame, MSB first
module ssu_peer (
    // Frame start, used in slave role only
    input  wire logic       go,
    input  wire logic       sck,
    // Serial data
    input  wire logic       mosi,
    output logic            miso,
    output logic            sck_out,
    // Byte to send, byte seen, rising edges seen
    input  wire logic [7:0] tx_byte,
    output logic      [7:0] rx_byte,
    output int              edges
);
    logic [2:0] cnt = 3'h0;
    initial begin
        sck_out = 1'b0;
        rx_byte = 8'h00;
        edges = 0;
    end
    // Clock stands still low between frames
    always @(posedge go) begin
        repeat (8) begin
            #6 sck_out = 1'b1;
            #6 sck_out = 1'b0;
        end
    end
    // Sample on the rise; the next bit follows just after it
    always @(posedge sck) begin
        rx_byte <= {rx_byte[6:0], mosi};
        cnt <= cnt + 3'h1;
        edges <= edges + 1;
    end
    assign miso = tx_byte[~cnt];
endmodule

// ### ssu_sync_serial_tb.sv
`timescale 1ns/100ps
// ==========================================================
// Bench: sequences of strobes with expected flags and bytes
module ssu_sync_serial_tb;
    `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
        $display("Error %s expected %h seen %h", n, e, g); end end
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       module_standby = 1'b0;
    logic       master_select = 1'b1;
    logic       tx_allow = 1'b0;
    logic       rx_allow = 1'b0;
    logic [2:0] irq_en = 3'h7;
    logic       tx_wr = 1'b0;
    logic [7:0] tx_wdata = 8'h00;
    logic       rx_rd = 1'b0;
    logic       overrun_clr = 1'b0;
    logic       go = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] rx_data_reg, peer_rx;
    logic       tx_empty_flag, tx_done_flag, rx_full_flag, overrun_flag;
    logic       tx_irq, rx_irq, error_irq, tx_dma_req, rx_dma_req;
    logic       sck_o, oe_n, peer_sck, sout, sin;
    int         edges, e0;
    int         failures = 0;
    int         checks = 0;
    wire logic  sck_w = master_select ? sck_o : peer_sck;

    ssu_sync_serial i_ssu_sync_serial (.clk, .rst, .module_standby, .master_select, .tx_allow, .rx_allow,
        .tx_empty_irq_en(irq_en[0]), .tx_done_irq_en(irq_en[1]), .rx_full_irq_en(irq_en[2]),
        .tx_wr, .tx_wdata, .rx_rd, .overrun_clr, .rx_data_reg, .tx_empty_flag, .tx_done_flag,
        .rx_full_flag, .overrun_flag, .tx_irq, .rx_irq, .error_irq, .tx_dma_req, .rx_dma_req,
        .shift_clock_pin_i(sck_w), .shift_clock_pin_o(sck_o), .shift_clock_pin_oe_n(oe_n),
        .serial_in_pin(sin), .serial_out_pin(sout));
    ssu_peer i_ssu_peer (.go, .sck(sck_w), .mosi(sout), .miso(sin), .sck_out(peer_sck),
        .tx_byte(peer_tx), .rx_byte(peer_rx), .edges);

    always #12.5 clk = ~clk;

    // Strobes are one cycle wide, launched at a falling edge
    task automatic wr(input logic [7:0] d);
        @(negedge clk);
        tx_wr = 1'b1;
        tx_wdata = d;
        @(negedge clk);
        tx_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] e);
        @(negedge clk);
        `CHK("rx_data_reg", e, rx_data_reg)
        rx_rd = 1'b1;
        @(negedge clk);
        rx_rd = 1'b0;
    endtask
    // Bounded wait on rx full (0), tx done (1) or overrun (2)
    task automatic wait_on(input int sel);
        int n = 0;
        while (!(sel == 0 ? rx_full_flag : sel == 1 ? tx_done_flag : overrun_flag) && n < 1500) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1500) begin
            failures++;
            $display("Error wait %0d expected 1 seen 0", sel);
            results();
        end
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("tx_empty", 1'b1, tx_empty_flag)
        `CHK("serial_out", 1'b1, sout)
        `CHK("oe_n", 1'b0, oe_n)
        module_standby = 1'b1;
        tx_allow = 1'b1;
        repeat (2) @(negedge clk);
        wr(8'h81);
        repeat (100) @(negedge clk);
        `CHK("standby edges", 0, edges)
        module_standby = 1'b0;
        tx_allow = 1'b0;
        $display("test reset and standby done");
        // Full duplex master, second byte queued behind the first
        repeat (4) @(negedge clk);
        tx_allow = 1'b1;
        rx_allow = 1'b1;
        peer_tx = 8'h3C;
        wr(8'hA5);
        wr(8'h5A);
        `CHK("tx_empty pending", 1'b0, tx_empty_flag)
        wait_on(0);
        `CHK("peer byte 1", 8'hA5, peer_rx)
        `CHK("rx_irq", 1'b1, rx_irq)
        rd(8'h3C);
        `CHK("rx_full", 1'b0, rx_full_flag)
        wait_on(0);
        `CHK("peer byte 2", 8'h5A, peer_rx)
        rd(8'h3C);
        wait_on(1);
        `CHK("tx_done", 1'b1, tx_done_flag)
        irq_en = 3'h6;
        @(negedge clk);
        `CHK("tx_irq", 1'b1, tx_irq)
        irq_en = 3'h7;
        tx_allow = 1'b0;
        rx_allow = 1'b0;
        $display("test full duplex done");
        // Receive-only master left unread until overrun
        repeat (4) @(negedge clk);
        peer_tx = 8'hC6;
        rx_allow = 1'b1;
        wait_on(0);
        wait_on(2);
        `CHK("error_irq", 1'b1, error_irq)
        e0 = edges;
        repeat (400) @(negedge clk);
        `CHK("rx stopped", e0, edges)
        rx_allow = 1'b0;
        tx_allow = 1'b1;
        wr(8'h11);
        repeat (100) @(negedge clk);
        `CHK("tx blocked", e0, edges)
        tx_allow = 1'b0;
        `CHK("rx_full kept", 1'b1, rx_full_flag)
        `CHK("overrun kept", 1'b1, overrun_flag)
        @(negedge clk);
        overrun_clr = 1'b1;
        @(negedge clk);
        overrun_clr = 1'b0;
        rd(8'hC6);
        `CHK("overrun", 1'b0, overrun_flag)
        $display("test overrun done");
        // Slave role, clock from the far side
        master_select = 1'b0;
        tx_allow = 1'b1;
        rx_allow = 1'b1;
        peer_tx = 8'h96;
        wr(8'hC3);
        `CHK("oe_n slave", 1'b1, oe_n)
        `CHK("tx_done cleared", 1'b0, tx_done_flag)
        repeat (4) @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        wait_on(0);
        `CHK("peer slave byte", 8'hC3, peer_rx)
        rd(8'h96);
        wait_on(1);
        $display("test slave done");
        results();
    end
endmodule

bind ssu_sync_serial ssu_props i_ssu_props (.clk, .rst, .module_standby, .master_select, .tx_allow, .tx_wr,
    .rx_rd, .overrun_clr, .tx_empty_irq_en, .tx_done_irq_en, .rx_full_irq_en, .tx_empty_flag, .tx_done_flag,
    .rx_full_flag, .overrun_flag, .tx_irq, .rx_irq, .error_irq, .tx_dma_req, .rx_dma_req,
    .shift_clock_pin_oe_n);
